// file: spt_pkg.sv
// Shared constants, register map and types of the transmit packet and management port.
package spt_pkg;
	// Register byte offsets relative to the physical-layer base address.
	localparam logic [7:0] REG_HEADER = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_EVENT = 8'h0c;
	localparam logic [7:0] REG_INT_EN = 8'h10;
	localparam logic [7:0] REG_LIMITS = 8'h14;
	localparam logic [7:0] REG_PKT_CNT = 8'h18;
	// Size of the decoded register window in bytes.
	localparam logic [31:0] REG_SPAN = 32'h0000_0020;
	// Control register bit positions.
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_ABORT = 1;
	localparam int CTRL_REINIT = 2;
	// Transmit enable value after reset.
	localparam logic CTRL_TX_EN_RST = 1'h1;
	// Event register bit positions and width.
	localparam int EV_DEV_ABORT = 0;
	localparam int EV_USR_ABORT = 1;
	localparam int EV_RX_SIZE = 2;
	localparam int EV_RX_IDLE = 3;
	localparam int EV_PKT_DONE = 4;
	localparam int EV_W = 5;
	// Field positions in the header, status and limits registers.
	localparam int HDR_EFP_LSB = 16;
	localparam int ST_READY = 0;
	localparam int ST_SILENT = 1;
	localparam int ST_IN_PKT = 2;
	localparam int ST_ACKID_LSB = 8;
	localparam int ST_PRIO_LSB = 16;
	localparam int LIM_IDLE_LSB = 16;
	// Documented defaults of the build-time settings.
	localparam logic [31:0] DEF_PHY_BASE = 32'h0000_0000;
	localparam logic [15:0] DEF_EXT_FEATURES_POINTER = 16'h0000;
	localparam logic [15:0] DEF_SILENCE_COUNT = 16'h00ff;
	localparam logic [9:0] DEF_MAX_PKT_BYTES = 10'h114;
	localparam logic [7:0] DEF_RX_IDLE_LIMIT = 8'hff;
	// Bytes carried by one full data word.
	localparam logic [3:0] WORD_BYTES = 4'h8;
	// Reset value of the acknowledge identifier.
	localparam logic [4:0] ACKID_RST = 5'h00;

	// One word taken from the user transmit FIFO.
	typedef struct packed {
		logic [63:0] data;
		logic sof;
		logic eof;
		logic [3:0] half_en;
	} spt_word_t;

	// Transmit packet acceptance states.
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_PKT = 3'b010,
		TX_DROP = 3'b100
	} spt_tx_state_t;

	// Bytes carried by the valid 16-bit halves of a final word.
	function automatic logic [3:0] spt_half_bytes(input logic [3:0] en);
		logic [3:0] sum;
		sum = 4'h0;
		for (int i = 0; i < 4; i++) begin
			sum = sum + {2'h0, en[i], 1'h0};
		end
		return sum;
	endfunction
endpackage

// file: spt_limit_chk.sv
// Running count of a packet quantity, compared against a limit.
`timescale 1ns/1ps
`default_nettype none
module spt_limit_chk #(
	parameter int W = 10
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Count control.
	input wire logic clear,
	input wire logic inc,
	input wire logic [3:0] amount,
	input wire logic [W-1:0] limit,
	// Result.
	output logic hit,
	output logic over
);
	// Count so far in the current packet.
	logic [W-1:0] count;
	// Count base after an optional clear.
	logic [W-1:0] base;
	// Count plus the new amount, one bit wider to catch wrap.
	logic [W:0] sum;

	// A clear restarts the count with the same cycle's amount.
	always_comb begin
		base = clear ? '0 : count;
		sum = {1'b0, base} + {{(W-3){1'b0}}, amount};
		hit = inc && (sum > {1'b0, limit});
	end

	// Count saturates once the limit is passed, so it cannot wrap back below it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			over <= 1'b0;
		end else begin
			if (clear) begin
				over <= hit;
			end else if (hit) begin
				over <= 1'b1;
			end
			if (inc && !sum[W] && !(over && !clear)) begin
				count <= sum[W-1:0];
			end else if (clear) begin
				count <= '0;
			end
		end
	end
endmodule // spt_limit_chk
`default_nettype wire

// file: spt_tx_mgmt.sv
// Transmit user packet port with a Wishbone management register file.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Device pulses transmit abort to end packet.
// - Release strobe qualifies released acknowledge identifier.
// - Device raises read to fetch next word.
// - Device acknowledges after capturing or presenting data; writes are captured one cycle after the acknowledge rises.
// - Thirty-two bit address and data buses.
// - Registers decoded from a configurable base.
// - Header reports extended features pointer.
// - Silent state lasts configurable count.
// - Receiver discards packets above maximum size.
// - Receiver discards packets with excess idles.
// - Ready low makes user signals invalid.
// - One system clock, active-low reset.
module spt_tx_mgmt
	import spt_pkg::*;
#(
	parameter logic [31:0] PHY_BASE = DEF_PHY_BASE,
	parameter logic [15:0] EXT_FEATURES_POINTER = DEF_EXT_FEATURES_POINTER,
	parameter logic [15:0] SILENCE_COUNT = DEF_SILENCE_COUNT,
	parameter logic [9:0] MAX_PKT_BYTES = DEF_MAX_PKT_BYTES,
	parameter logic [7:0] RX_IDLE_LIMIT = DEF_RX_IDLE_LIMIT
) (
	// System clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Transmit user interface.
	output logic tx_ready,
	output logic tx_dev_abort,
	input wire logic tx_usr_abort,
	input wire logic [1:0] tx_prio,
	output logic [4:0] tx_next_ackid,
	output logic [4:0] tx_release_ackid,
	output logic tx_release_val,
	// User transmit FIFO.
	input wire logic [63:0] fifo_data,
	input wire logic fifo_alm_empty,
	output logic fifo_read,
	input wire logic fifo_sof,
	input wire logic fifo_eof,
	input wire logic [3:0] fifo_half_en,
	input wire logic fifo_data_avail,
	// Accepted words toward the lane side.
	output spt_word_t lane_word,
	output logic [1:0] lane_prio,
	output logic lane_word_valid,
	// Receive symbol monitor.
	input wire logic rx_word_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [3:0] rx_half_en,
	input wire logic rx_idle,
	output logic rx_discard,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Management interrupt.
	output logic mgmt_int
);
	// Address relative to the base, hit flag and local offset.
	logic [31:0] rel_adr;
	logic adr_hit;
	logic [7:0] adr_off;
	// Write fires at the edge where the master samples the acknowledge.
	logic wr_fire;
	logic [31:0] next_rdata;
	// Control state written by software.
	logic tx_en;
	logic sw_abort;
	logic sw_reinit;
	logic [EV_W-1:0] int_en;
	// Sticky events and their set terms.
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] ev_set;
	// Silent link state and its counter.
	logic silent;
	logic [15:0] silence_cnt;
	// Delayed read, so the FIFO word is taken one cycle after the request.
	logic read_q;
	logic word_ok;
	spt_word_t in_word;
	// Transmit state.
	spt_tx_state_t tx_state;
	spt_tx_state_t next_tx_state;
	logic [1:0] pkt_prio;
	logic [15:0] pkt_cnt;
	// Decisions taken on the current word.
	logic do_dev_abort;
	logic do_usr_abort;
	logic do_release;
	logic [3:0] tx_amount;
	logic tx_size_hit;
	logic tx_size_over;
	// Receive monitor state.
	logic rx_in_pkt;
	logic [3:0] rx_amount;
	logic rx_size_hit;
	logic rx_idle_hit;
	logic rx_size_over;
	logic rx_idle_over;
	logic rx_bad;

	always_comb begin
		rel_adr = wb_adr_i - PHY_BASE;
		adr_hit = rel_adr < REG_SPAN;
		adr_off = rel_adr[7:0];
	end

	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && adr_hit;

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (adr_hit) begin
			case (adr_off)
				REG_HEADER: next_rdata[HDR_EFP_LSB +: 16] = EXT_FEATURES_POINTER;
				REG_CTRL: next_rdata[CTRL_TX_EN] = tx_en;
				REG_STATUS: begin
					next_rdata[ST_READY] = tx_ready;
					next_rdata[ST_SILENT] = silent;
					next_rdata[ST_IN_PKT] = tx_state == TX_PKT;
					next_rdata[ST_ACKID_LSB +: 5] = tx_next_ackid;
					next_rdata[ST_PRIO_LSB +: 2] = pkt_prio;
				end
				REG_EVENT: next_rdata[EV_W-1:0] = events;
				REG_INT_EN: next_rdata[EV_W-1:0] = int_en;
				REG_LIMITS: begin
					next_rdata[9:0] = MAX_PKT_BYTES;
					next_rdata[LIM_IDLE_LSB +: 8] = RX_IDLE_LIMIT;
				end
				REG_PKT_CNT: next_rdata[15:0] = pkt_cnt;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// Control register; abort and reinit are self-clearing pulses.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_en <= CTRL_TX_EN_RST;
			sw_abort <= 1'b0;
			sw_reinit <= 1'b0;
		end else begin
			sw_abort <= 1'b0;
			sw_reinit <= 1'b0;
			if (wr_fire && adr_off == REG_CTRL && wb_sel_i[0]) begin
				tx_en <= wb_dat_i[CTRL_TX_EN];
				sw_abort <= wb_dat_i[CTRL_ABORT];
				sw_reinit <= wb_dat_i[CTRL_REINIT];
			end
		end
	end

	// Event set terms from the transmit and receive logic.
	always_comb begin
		ev_set = '0;
		ev_set[EV_DEV_ABORT] = do_dev_abort;
		ev_set[EV_USR_ABORT] = do_usr_abort;
		ev_set[EV_RX_SIZE] = rx_in_pkt && rx_size_hit;
		ev_set[EV_RX_IDLE] = rx_in_pkt && rx_idle_hit;
		ev_set[EV_PKT_DONE] = do_release;
	end

	// Sticky events, write one to clear; a new event wins over its clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			events <= '0;
		end else if (wr_fire && adr_off == REG_EVENT && wb_sel_i[0]) begin
			events <= (events & ~wb_dat_i[EV_W-1:0]) | ev_set;
		end else begin
			events <= events | ev_set;
		end
	end

	// Interrupt enable register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_en <= '0;
		end else if (wr_fire && adr_off == REG_INT_EN && wb_sel_i[0]) begin
			int_en <= wb_dat_i[EV_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmt_int <= 1'b0;
		end else begin
			mgmt_int <= |(events & int_en);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			silent <= 1'b1;
			silence_cnt <= SILENCE_COUNT;
		end else if (sw_reinit) begin
			silent <= 1'b1;
			silence_cnt <= SILENCE_COUNT;
		end else if (silent) begin
			silence_cnt <= silence_cnt - 16'h0001;
			if (silence_cnt == 16'h0001) begin
				silent <= 1'b0;
			end
		end
	end

	// ready from enable and link state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= tx_en && !silent;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_read <= 1'b0;
			read_q <= 1'b0;
		end else begin
			fifo_read <= tx_ready && fifo_data_avail && !(fifo_read && fifo_alm_empty);
			read_q <= fifo_read;
		end
	end

	always_comb begin
		word_ok = read_q && tx_ready;
		in_word.data = fifo_data;
		in_word.sof = fifo_sof;
		in_word.eof = fifo_eof;
		in_word.half_en = fifo_half_en;
	end

	assign tx_amount = in_word.eof ? spt_half_bytes(in_word.half_en) : WORD_BYTES;

	// Transmit packet size tracker.
	spt_limit_chk #(
		.W(10)
	) u_tx_size (
		.clk(clk),
		.rst_n(rst_n),
		.clear(word_ok && in_word.sof),
		.inc(word_ok),
		.amount(tx_amount),
		.limit(MAX_PKT_BYTES),
		.hit(tx_size_hit),
		.over(tx_size_over)
	);

	// Packet acceptance decisions and next state.
	always_comb begin
		next_tx_state = tx_state;
		do_dev_abort = 1'b0;
		do_usr_abort = 1'b0;
		do_release = 1'b0;
		case (tx_state)
			TX_IDLE: begin
				if (word_ok && in_word.sof) begin
					if (tx_size_hit) begin
						do_dev_abort = 1'b1;
						next_tx_state = in_word.eof ? TX_IDLE : TX_DROP;
					end else if (in_word.eof) begin
						do_release = 1'b1;
					end else begin
						next_tx_state = TX_PKT;
					end
				end
			end
			TX_PKT: begin
				if (tx_ready && tx_usr_abort) begin
					do_usr_abort = 1'b1;
					next_tx_state = TX_IDLE;
				end else if (sw_abort || (word_ok && (in_word.sof || tx_size_hit))) begin
					// Oversize, software abort or a restart mid-packet end it.
					do_dev_abort = 1'b1;
					next_tx_state = (word_ok && in_word.eof) ? TX_IDLE : TX_DROP;
				end else if (word_ok && in_word.eof) begin
					do_release = 1'b1;
					next_tx_state = TX_IDLE;
				end
			end
			TX_DROP: begin
				// Discard until the end marker of the aborted packet or a user abort.
				if ((word_ok && in_word.eof) || (tx_ready && tx_usr_abort)) begin
					next_tx_state = TX_IDLE;
				end
			end
			default: next_tx_state = TX_IDLE;
		endcase
	end

	// Transmit state register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= TX_IDLE;
		end else begin
			tx_state <= next_tx_state;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_dev_abort <= 1'b0;
		end else begin
			tx_dev_abort <= do_dev_abort;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pkt_prio <= 2'h0;
		end else if (word_ok && in_word.sof) begin
			pkt_prio <= tx_prio;
		end
	end

	// Accepted words go on toward the lanes while a packet is good.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_word <= '0;
			lane_prio <= 2'h0;
			lane_word_valid <= 1'b0;
		end else begin
			lane_word_valid <= word_ok && !do_dev_abort && !do_usr_abort &&
				(next_tx_state == TX_PKT || do_release);
			if (word_ok) begin
				lane_word <= in_word;
				lane_prio <= in_word.sof ? tx_prio : pkt_prio;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_next_ackid <= ACKID_RST;
			tx_release_ackid <= ACKID_RST;
			tx_release_val <= 1'b0;
			pkt_cnt <= 16'h0000;
		end else begin
			tx_release_val <= do_release;
			if (do_release) begin
				tx_release_ackid <= tx_next_ackid;
				tx_next_ackid <= tx_next_ackid + 5'h01;
				pkt_cnt <= pkt_cnt + 16'h0001;
			end
		end
	end

	// Receive packet framing for the discard monitor.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_in_pkt <= 1'b0;
		end else if (rx_word_valid && rx_sof && !rx_eof) begin
			rx_in_pkt <= 1'b1;
		end else if ((rx_word_valid && rx_eof) || rx_bad) begin
			rx_in_pkt <= 1'b0;
		end
	end

	assign rx_amount = rx_eof ? spt_half_bytes(rx_half_en) : WORD_BYTES;

	spt_limit_chk #(
		.W(10)
	) u_rx_size (
		.clk(clk),
		.rst_n(rst_n),
		.clear(rx_word_valid && rx_sof),
		.inc(rx_word_valid),
		.amount(rx_amount),
		.limit(MAX_PKT_BYTES),
		.hit(rx_size_hit),
		.over(rx_size_over)
	);

	spt_limit_chk #(
		.W(9)
	) u_rx_idle (
		.clk(clk),
		.rst_n(rst_n),
		.clear(rx_word_valid && rx_sof),
		.inc(rx_idle && rx_in_pkt),
		.amount(4'h1),
		.limit({1'b0, RX_IDLE_LIMIT}),
		.hit(rx_idle_hit),
		.over(rx_idle_over)
	);

	// A packet is bad the first time either limit is passed inside it.
	assign rx_bad = (rx_in_pkt || (rx_word_valid && rx_sof)) &&
		((rx_size_hit && !rx_size_over) || (rx_idle_hit && !rx_idle_over));

	// Receive discard pulse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_discard <= 1'b0;
		end else begin
			rx_discard <= rx_bad;
		end
	end
endmodule // spt_tx_mgmt
`default_nettype wire

// file: spt_user_model.sv
// User transmit FIFO model that hands one stored word to the block per read request.
`timescale 1ns/1ps
`default_nettype none
module spt_user_model
	import spt_pkg::*;
(
	// Clock, reset and request.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fifo_read,
	// FIFO word and flags.
	output logic [63:0] fifo_data,
	output logic fifo_sof,
	output logic fifo_eof,
	output logic [3:0] fifo_half_en,
	output logic fifo_alm_empty,
	output logic fifo_data_avail
);
	// Stored words; the bench reads the fill level from the queue size.
	spt_word_t q[$];
	// Loads one word; the bench loads whole packets before they are read.
	task automatic push(input spt_word_t w);
		q.push_back(w);
	endtask
	// word with markers
	// Flags are registered from the level left after a pop, so the block never races them.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{fifo_data, fifo_sof, fifo_eof, fifo_half_en} <= '0;
			fifo_alm_empty <= 1'b1;
			fifo_data_avail <= 1'b0;
		end else begin
			if (fifo_read && q.size() > 0) begin
				{fifo_data, fifo_sof, fifo_eof, fifo_half_en} <= q.pop_front();
			end else begin
				// No word read: data and enables keep toggling, markers stay low.
				fifo_data <= ~fifo_data;
				fifo_half_en <= ~fifo_half_en;
				fifo_sof <= 1'b0;
				fifo_eof <= 1'b0;
			end
			fifo_alm_empty <= (q.size() <= 1);
			fifo_data_avail <= (q.size() > 0);
		end
	end
endmodule // spt_user_model
`default_nettype wire

// file: spt_tx_mgmt_chk.sv
// Concurrent checks on the ports of the transmit and management block.
`timescale 1ns/1ps
`default_nettype none
module spt_tx_mgmt_chk
	import spt_pkg::*;
#(
	parameter logic [15:0] SILENCE_COUNT = DEF_SILENCE_COUNT
) (
	// Clock, reset and bus.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Transmit side.
	input wire logic tx_ready,
	input wire logic tx_dev_abort,
	input wire logic [4:0] tx_next_ackid,
	input wire logic [4:0] tx_release_ackid,
	input wire logic tx_release_val,
	input wire logic fifo_read,
	input wire logic fifo_alm_empty,
	input wire spt_word_t lane_word,
	input wire logic lane_word_valid
);
	// Cycles since reset release, saturating.
	logic [16:0] up_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			up_cnt <= 17'h0;
		end else if (!up_cnt[16]) begin
			up_cnt <= up_cnt + 17'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Bus request followed by a single-cycle acknowledge.
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ack; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_req |-> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("bus ack late or long");
	property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_rel_pulse; tx_release_val |=> !tx_release_val; endproperty
	a_rel_pulse: assert property (p_rel_pulse) else $error("release strobe long");
	property p_rel_id; tx_release_val |-> tx_next_ackid == 5'(tx_release_ackid + 5'h1); endproperty
	a_rel_id: assert property (p_rel_id) else $error("release id not next minus one");
	property p_rel_eof; tx_release_val |-> lane_word_valid && lane_word.eof; endproperty
	a_rel_eof: assert property (p_rel_eof) else $error("release without final word");
	property p_lane_read; lane_word_valid |-> $past(fifo_read, 2); endproperty
	a_lane_read: assert property (p_lane_read) else $error("word without read");
	property p_lane_ready; lane_word_valid |-> $past(tx_ready); endproperty
	a_lane_ready: assert property (p_lane_ready) else $error("word taken while not ready");
	property p_read_alm; fifo_read && fifo_alm_empty |=> !fifo_read; endproperty
	a_read_alm: assert property (p_read_alm) else $error("read past almost empty");
	property p_abort_pulse; tx_dev_abort |=> !tx_dev_abort; endproperty
	a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse long");
	property p_silent; up_cnt < {1'b0, SILENCE_COUNT} |-> !tx_ready; endproperty
	a_silent: assert property (p_silent) else $error("ready during silence");
	property p_wake; up_cnt == {1'b0, SILENCE_COUNT} + 17'h1 |-> ##[0:3] tx_ready; endproperty
	a_wake: assert property (p_wake) else $error("ready late after silence");
endmodule // spt_tx_mgmt_chk
bind spt_tx_mgmt spt_tx_mgmt_chk #(.SILENCE_COUNT(SILENCE_COUNT)) u_chk (.clk(clk),
	.rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.tx_ready(tx_ready), .tx_dev_abort(tx_dev_abort), .tx_next_ackid(tx_next_ackid),
	.tx_release_ackid(tx_release_ackid), .tx_release_val(tx_release_val),
	.fifo_read(fifo_read), .fifo_alm_empty(fifo_alm_empty), .lane_word(lane_word),
	.lane_word_valid(lane_word_valid));
`default_nettype wire

// file: spt_tx_mgmt_tb.sv
// Self-checking bench for the transmit port and its register file.
`timescale 1ns/1ps
`default_nettype none
module spt_tx_mgmt_tb;
	import spt_pkg::*;
	// Build settings under test; short silence and size keep the run brief.
	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam logic [15:0] EFP = 16'h5a3c;
	logic clk = 0, rst_n = 0, tx_usr_abort = 0, rx_word_valid = 0, rx_sof = 0, rx_eof = 0;
	logic rx_idle = 0, cyc = 0, stb = 0, we = 0;
	logic [1:0] tx_prio = 0;
	logic [3:0] rx_half_en = 0, sel = 0;
	logic [31:0] adr = 0, wdat = 0, q;
	logic tx_ready, tx_dev_abort, tx_release_val, fifo_read, fifo_sof, fifo_eof, lane_word_valid;
	logic fifo_alm_empty, fifo_data_avail, rx_discard, wb_ack_o, mgmt_int;
	logic [4:0] tx_next_ackid, tx_release_ackid, rel_id;
	logic [1:0] lane_prio, lane_pr;
	logic [63:0] fifo_data;
	logic [3:0] fifo_half_en;
	logic [31:0] wb_dat_o;
	spt_word_t lane_word;
	int n_mismatch = 0, n_compared = 0, n_lane = 0, n_rel = 0, n_dab = 0, n_rxd = 0, k;
	initial forever #20 clk = ~clk;
	spt_tx_mgmt #(.PHY_BASE(BASE), .EXT_FEATURES_POINTER(EFP), .SILENCE_COUNT(16'h0003),
		.MAX_PKT_BYTES(10'h020), .RX_IDLE_LIMIT(8'h02)) dut (.clk(clk), .rst_n(rst_n),
		.tx_ready(tx_ready), .tx_dev_abort(tx_dev_abort), .tx_usr_abort(tx_usr_abort),
		.tx_prio(tx_prio), .tx_next_ackid(tx_next_ackid), .tx_release_ackid(tx_release_ackid),
		.tx_release_val(tx_release_val), .fifo_data(fifo_data), .fifo_alm_empty(fifo_alm_empty),
		.fifo_read(fifo_read), .fifo_sof(fifo_sof), .fifo_eof(fifo_eof),
		.fifo_half_en(fifo_half_en), .fifo_data_avail(fifo_data_avail), .lane_word(lane_word),
		.lane_prio(lane_prio), .lane_word_valid(lane_word_valid), .rx_word_valid(rx_word_valid),
		.rx_sof(rx_sof), .rx_eof(rx_eof), .rx_half_en(rx_half_en), .rx_idle(rx_idle),
		.rx_discard(rx_discard), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.mgmt_int(mgmt_int));
	spt_user_model m (.clk(clk), .rst_n(rst_n), .fifo_read(fifo_read), .fifo_data(fifo_data),
		.fifo_sof(fifo_sof), .fifo_eof(fifo_eof), .fifo_half_en(fifo_half_en),
		.fifo_alm_empty(fifo_alm_empty), .fifo_data_avail(fifo_data_avail));
	// Counts pulses of the block's outputs.
	always @(posedge clk) begin
		if (lane_word_valid === 1'b1) begin
			n_lane++;
			lane_pr = lane_prio;
		end
		if (tx_release_val === 1'b1) begin
			n_rel++;
			rel_id = tx_release_ackid;
		end
		if (tx_dev_abort === 1'b1) n_dab++;
		if (rx_discard === 1'b1) n_rxd++;
	end
	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic Wishbone cycle, held until ack is sampled.
	task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hf, BASE + {24'h0, off}, d};
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rd(input string nm, input logic [7:0] off, input logic [31:0] mk,
		input logic [31:0] e);
		bus(1'b0, off, 32'h0);
		chk(nm, e, q & mk);
	endtask
	// Loads a packet of n words and optionally waits until it has drained.
	task automatic pkt(input int n, input logic [3:0] he, input logic dr);
		for (int i = 0; i < n; i++) m.push('{64'(i) ^ 64'h0f0f, i == 0, i == n - 1,
			(i == n - 1) ? he : 4'h0});
		for (k = 0; dr && m.q.size() > 0 && k < 300; k++) @(posedge clk);
		repeat (6) @(posedge clk);
	endtask
	// Sends a receive packet of nw words with ni idles after its start word.
	task automatic rx(input int nw, input int ni);
		for (int i = 0; i < nw + ni; i++) begin
			@(posedge clk);
			{rx_word_valid, rx_sof, rx_eof, rx_half_en} <= {i == 0 || i > ni, i == 0,
				i == nw + ni - 1, 4'hf};
			rx_idle <= (i > 0 && i <= ni);
		end
		@(posedge clk);
		{rx_word_valid, rx_sof, rx_eof, rx_idle} <= 4'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		conclude;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd("ext_features_pointer", REG_HEADER, 32'hffff_0000, {EFP, 16'h0});
		rd("limits", REG_LIMITS, 32'h00ff_03ff, 32'h0002_0020);
		rd("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
		for (k = 0; tx_ready !== 1'b1 && k < 100; k++) @(posedge clk);
		chk("tx_ready", 1, tx_ready);
		$display("test registers done");
		tx_prio <= 2'h2;
		pkt(3, 4'b0011, 1);
		chk("lane words", 3, n_lane);
		chk("lane prio", 2, lane_pr);
		chk("release id", 0, rel_id);
		chk("next ackid", 1, tx_next_ackid);
		rd("prio", REG_STATUS, 32'h0003_0000, 32'h0002_0000);
		rd("pkt count", REG_PKT_CNT, 32'h0000_ffff, 1);
		$display("test good packet done");
		pkt(5, 4'hf, 1);
		chk("device aborts", 1, n_dab);
		chk("releases after size abort", 1, n_rel);
		$display("test oversize done");
		m.push('{64'h1, 1'b1, 1'b0, 4'h0});
		m.push('{64'h2, 1'b0, 1'b0, 4'h0});
		m.push('{64'h3, 1'b0, 1'b1, 4'hf});
		for (k = 0; lane_word_valid !== 1'b1 && k < 50; k++) @(posedge clk);
		tx_usr_abort <= 1'b1;
		@(posedge clk);
		tx_usr_abort <= 1'b0;
		pkt(0, 4'h0, 1);
		chk("releases after user abort", 1, n_rel);
		$display("test user abort done");
		rx(2, 0);
		chk("rx good", 0, n_rxd);
		rx(5, 0);
		chk("rx size", 1, n_rxd);
		rx(2, 3);
		chk("rx idles", 2, n_rxd);
		rd("events", REG_EVENT, 32'h1f, 32'h1f);
		$display("test receive done");
		bus(1'b1, REG_INT_EN, 32'h1);
		repeat (2) @(posedge clk);
		chk("int on", 1, mgmt_int);
		bus(1'b1, REG_EVENT, 32'h1f);
		repeat (2) @(posedge clk);
		chk("int off", 0, mgmt_int);
		rd("events cleared", REG_EVENT, 32'h1f, 32'h0);
		$display("test interrupt done");
		bus(1'b1, REG_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk("ready off", 0, tx_ready);
		pkt(2, 4'h1, 0);
		chk("no words while off", 9, n_lane);
		bus(1'b1, REG_CTRL, 32'h1);
		pkt(0, 4'h0, 1);
		chk("release id 2", 1, rel_id);
		chk("releases", 2, n_rel);
		$display("test ready gating done");
		conclude;
	end
endmodule // spt_tx_mgmt_tb
`default_nettype wire
